/* design/decim_filter.sv */
// multistage decimation filter with register port and tagged output
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "decim_regs.svh"
module decim_filter #(
    parameter int W = 24,
    parameter int NS = 23
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_valid,
    input wire logic [W-1:0] i_re,
    input wire logic [W-1:0] i_im,
    output logic o_valid,
    output logic o_two_words,
    output logic [31:0] o_word_a,
    output logic [31:0] o_word_b,
    output logic o_trig_valid,
    output logic [31:0] o_trig_data,
    output logic o_running
);
    // levels up to the top need tap 23; the pass tag holds at most 31
    if (W < 16 || W > 32 || NS < 23 || NS > 31) begin : g_bad_param
        $error("decim_filter: unsupported W or NS");
    end

    typedef struct packed {
        decim_pkg::run_state_t run;
        logic [4:0] lvl;
        logic [4:0] tlvl;
        decim_pkg::halving_t extra;
        decim_pkg::out_mode_t mode;
        decim_pkg::tag_place_t tag;
        logic prec16;
        logic cplx;
        logic [3:0] err;
        logic xphase;
        logic tphase;
        logic [NS:1] pend_v;
        logic [NS:1][W-1:0] pend_re;
        logic [NS:1][W-1:0] pend_im;
        logic out_valid;
        logic out_two;
        logic [31:0] word_a;
        logic [31:0] word_b;
        logic trig_valid;
        logic [31:0] trig_data;
        logic [31:0] rdata;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic [NS:0] tap_v;
    logic [NS:0][W-1:0] tap_re;
    logic [NS:0][W-1:0] tap_im;
    logic flush;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // clamp at top level
    function automatic logic [4:0] clamp_lvl(input logic [7:0] lv,
                                             input logic ex);
        logic [4:0] lim;
        lim = ex ? `MAX_LEVEL_EXTRA : `MAX_LEVEL;
        if (lv > {3'h0, lim}) begin
            return lim;
        end
        return lv[4:0];
    endfunction : clamp_lvl

    function automatic logic [4:0] tap_of(input logic [4:0] lv);
        return (lv == 5'h00) ? 5'h00 : lv - 5'h01;
    endfunction : tap_of

    // left-justify a sample into the 32-bit output word
    function automatic logic [31:0] just(input logic [W-1:0] v);
        logic [31:0] x;
        x = 32'(v);
        return x << (32 - W);
    endfunction : just

    function automatic logic [31:0] tag32(input logic [W-1:0] v,
                                          input logic [4:0] t,
                                          input logic on,
                                          input logic up24);
        logic [31:0] b;
        b = just(v);
        if (!on) begin
            return b;
        end
        if (up24) begin
            // tag in the lowest bits of the upper 24 bits
            b[`TAG_LSB_24 +: `TAG_W] = t;
        end else begin
            b[`TAG_W-1:0] = t;
        end
        return b;
    endfunction : tag32

    function automatic logic [31:0] pack16(input logic [W-1:0] r,
                                           input logic [W-1:0] i,
                                           input logic cx,
                                           input logic [4:0] t,
                                           input logic on);
        logic [15:0] r16;
        logic [15:0] i16;
        r16 = 16'(just(r) >> 16);
        i16 = 16'(just(i) >> 16);
        if (cx) begin
            if (on) begin
                i16[`TAG_W-1:0] = t;
            end
            return {r16, i16};
        end
        return {r16, on ? {11'h000, t} : 16'h0000};
    endfunction : pack16

    // ------------------------------------------------------------
    // section chain
    // ------------------------------------------------------------
    // samples are ignored while idle, so stale pairs never seed a section
    // tap zero is the unfiltered stream
    assign tap_v[0] = i_valid && (st.run == decim_pkg::st_running);
    assign tap_re[0] = i_re;
    assign tap_im[0] = i_im;

    for (genvar k = 0; k < NS; k++) begin : g_sec
        halving_section #(.W(W)) u_sec (
            .i_mclk(i_mclk),
            .i_reset(i_reset),
            .i_flush(flush),
            .i_valid(tap_v[k]),
            .i_re(tap_re[k]),
            .i_im(tap_im[k]),
            .o_valid(tap_v[k+1]),
            .o_re(tap_re[k+1]),
            .o_im(tap_im[k+1])
        );
    end

    // the flush rides on the start strobe, so the first pair is fresh
    // a start from idle clears all section state
    assign flush = i_wr && (i_addr == `REG_CMD) && i_wdata[`F_START]
                   && (st.run == decim_pkg::st_idle);

    // ------------------------------------------------------------
    // control, registers and output
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] lv;
        logic [1:0] ex;
        logic [1:0] md;
        logic [1:0] tg;
        logic [3:0] eset;
        logic [3:0] eclr;
        logic [4:0] sel;
        logic [4:0] tsel;
        logic found;
        logic multi;
        lv = i_wdata[`F_LVL_MSB:0];
        ex = i_wdata[`F_EXTRA_LSB +: 2];
        md = i_wdata[`F_MODE_LSB +: 2];
        tg = i_wdata[`F_TAG_LSB +: 2];
        eset = 4'h0;
        eclr = 4'h0;
        sel = tap_of(st.lvl);
        tsel = tap_of(st.tlvl);
        found = 1'b0;
        multi = (st.mode == decim_pkg::multi_pass_output);
        next_st = st;
        next_st.out_valid = 1'b0;
        next_st.trig_valid = 1'b0;
        next_st.rdata = 32'h0000_0000;

        if (i_wr && i_addr == `REG_CFG) begin
            // each bad field flags its own error
            eset[decim_pkg::bad_bandwidth_level_error] = lv[7];
            // only zero and one are legal
            eset[decim_pkg::bad_extra_halving_error] = (ex > 2'h1);
            eset[decim_pkg::bad_output_mode_error] =
                (md > 2'h1) || (md == 2'h1 && lv != 8'h00);
            eset[decim_pkg::bad_tag_placement_error] =
                (md == 2'h1) && (tg > 2'h1);
            if (eset == 4'h0) begin
                // one level for data and trigger
                next_st.lvl = clamp_lvl(lv, ex[0]);
                next_st.tlvl = clamp_lvl(lv, ex[0]);
                next_st.extra = decim_pkg::halving_t'(ex);
                next_st.mode = decim_pkg::out_mode_t'(md);
                next_st.tag = decim_pkg::tag_place_t'(tg[0] ? 2'h1 : 2'h0);
                next_st.prec16 = i_wdata[`F_PREC16];
                next_st.cplx = i_wdata[`F_CPLX];
            end
        end
        // a trigger write keeps the halving already in force
        if (i_wr && i_addr == `REG_TRIG) begin
            eset[decim_pkg::bad_bandwidth_level_error] = lv[7];
            if (!lv[7]) begin
                next_st.tlvl = clamp_lvl(lv, st.extra[0]);
            end
        end
        if (i_wr && (i_addr == `REG_CFG || i_addr == `REG_TRIG)) begin
            next_st.run = decim_pkg::st_idle;
        end
        if (i_wr && i_addr == `REG_CMD) begin
            if (i_wdata[`F_STOP]) begin
                next_st.run = decim_pkg::st_idle;
            end else if (flush) begin
                next_st.run = decim_pkg::st_running;
                next_st.pend_v = '0;
                next_st.xphase = 1'b0;
                next_st.tphase = 1'b0;
            end
        end
        // clear bits are write-one, so a zero leaves an error standing
        if (i_wr && i_addr == `REG_STATUS) begin
            eclr = i_wdata[4:1];
        end
        // a new error wins over a clear in the same cycle
        next_st.err = (st.err & ~eclr) | eset;

        // nothing is delivered in the start cycle itself
        if (st.run == decim_pkg::st_running && !flush) begin
            if (!multi) begin
                if (tap_v[sel]) begin
                    next_st.xphase = st.xphase ^ st.extra[0];
                    // every sample when halving is off
                    if (!st.xphase || !st.extra[0]) begin
                        next_st.out_valid = 1'b1;
                        next_st.out_two = !st.prec16 && st.cplx;
                        if (st.prec16) begin
                            next_st.word_a = pack16(tap_re[sel], tap_im[sel],
                                                    st.cplx, 5'h00, 1'b0);
                            next_st.word_b = 32'h0000_0000;
                        end else begin
                            next_st.word_a = just(tap_re[sel]);
                            // imaginary word keeps the zoomed band
                            next_st.word_b = st.cplx ? just(tap_im[sel])
                                                     : 32'h0000_0000;
                        end
                    end
                end
            end else begin
                // one pass per cycle; a slot not drained in time is lost
                // lowest pending pass goes first
                for (int k = 1; k <= NS; k++) begin
                    if (st.pend_v[k] && !found) begin
                        found = 1'b1;
                        next_st.pend_v[k] = 1'b0;
                        next_st.out_valid = 1'b1;
                        next_st.out_two = !st.prec16 && st.cplx;
                        if (st.prec16) begin
                            next_st.word_a = pack16(st.pend_re[k],
                                                    st.pend_im[k], st.cplx,
                                                    5'(k), 1'b1);
                            next_st.word_b = 32'h0000_0000;
                        end else begin
                            next_st.word_a = tag32(st.pend_re[k], 5'(k),
                                                   1'b1, st.tag[0]);
                            next_st.word_b = st.cplx
                                ? tag32(st.pend_im[k], 5'(k), 1'b1, st.tag[0])
                                : 32'h0000_0000;
                        end
                    end
                end
                // a fresh sample wins over the slot just emptied
                for (int k = 1; k <= NS; k++) begin
                    if (tap_v[k]) begin
                        next_st.pend_v[k] = 1'b1;
                        next_st.pend_re[k] = tap_re[k];
                        next_st.pend_im[k] = tap_im[k];
                    end
                end
            end
            // trigger path taps its own level
            if (tap_v[tsel]) begin
                next_st.tphase = st.tphase ^ st.extra[0];
                if (!st.tphase || !st.extra[0]) begin
                    next_st.trig_valid = 1'b1;
                    next_st.trig_data = just(tap_re[tsel]);
                end
            end
        end

        // read data live one cycle, zero otherwise
        if (i_rd) begin
            unique case (i_addr)
                `REG_CFG: begin
                    next_st.rdata = {16'h0000, st.cplx, st.prec16,
                                     st.tag, st.mode, st.extra,
                                     3'h0, st.lvl};
                end
                `REG_TRIG: begin
                    next_st.rdata = {27'h0000000, st.tlvl};
                end
                `REG_STATUS: begin
                    next_st.rdata = {27'h0000000, st.err, st.run};
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register and outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_valid = st.out_valid;
    assign o_two_words = st.out_two;
    assign o_word_a = st.word_a;
    assign o_word_b = st.word_b;
    assign o_trig_valid = st.trig_valid;
    assign o_trig_data = st.trig_data;
    assign o_running = st.run;
endmodule : decim_filter

/* design/decim_pkg.sv */
// types shared by the decimation filter modules
package decim_pkg;
    typedef enum logic [1:0] {
        extra_halving_disabled = 2'h0,
        extra_halving_enabled = 2'h1
    } halving_t;
    typedef enum logic [1:0] {
        single_pass_output = 2'h0,
        multi_pass_output = 2'h1
    } out_mode_t;
    typedef enum logic [1:0] {
        tag_in_low_bits = 2'h0,
        tag_in_upper_24_bits = 2'h1
    } tag_place_t;
    typedef enum logic {
        st_idle = 1'b0,
        st_running = 1'b1
    } run_state_t;
    typedef enum logic [1:0] {
        bad_bandwidth_level_error = 2'h0,
        bad_extra_halving_error = 2'h1,
        bad_output_mode_error = 2'h2,
        bad_tag_placement_error = 2'h3
    } err_bit_t;
endpackage : decim_pkg

/* design/decim_regs.svh */
// register map, field positions and limits of the decimation filter
// How it works
// - a section keeps one output for every two inputs, averaging the pair
// - level zero takes the unfiltered converter stream straight out
// - a level above twenty-four is clamped to twenty-four
// - with extra halving on, the level is clamped to twenty-three
// - bad level, halving, mode or tag sets its own error, not applied
// - extra halving off delivers every sample of the chosen tap
// - extra halving on drops every second sample of the chosen tap
// - enabling extra halving pulls data and trigger level 24 to 23
// - output rate is Fs over two to the level plus halving minus one
// - zoomed band equals output rate; real band is half of it
// - extra halving field is zero for off and one for on
// - the filter is a chain of identical halving sections
// - single-pass mode delivers only the selected last section
// - multi-pass muxes all section outputs, legal only at level zero
// - multi-pass samples carry a five-bit pass number
// - tag placement is ignored in single-pass mode
// - 16-bit real precision carries the tag in an extra 16-bit word
// - low-bits placement puts the tag over the lowest word bits
// - upper-24 placement puts the tag in bits 12 to 8
// - 16-bit real: tag word zero but tag; complex: tag in imaginary
// - one level write sets data and trigger bandwidth alike
// - any decimation write while running returns the block to idle
`ifndef DECIM_REGS_SVH
`define DECIM_REGS_SVH
`define ADDR_W 4
`define REG_CFG 4'h0
`define REG_TRIG 4'h1
`define REG_CMD 4'h2
`define REG_STATUS 4'h3
`define F_LVL_MSB 7
`define F_EXTRA_LSB 8
`define F_MODE_LSB 10
`define F_TAG_LSB 12
`define F_PREC16 14
`define F_CPLX 15
`define F_START 0
`define F_STOP 1
`define MAX_LEVEL 5'h18
`define MAX_LEVEL_EXTRA 5'h17
`define TAG_LSB_24 8
`define TAG_W 5
`endif

/* design/halving_section.sv */
// one halving section of the decimation chain
`timescale 1ns/100ps
module halving_section #(
    parameter int W = 24
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_flush,
    input wire logic i_valid,
    input wire logic [W-1:0] i_re,
    input wire logic [W-1:0] i_im,
    output logic o_valid,
    output logic [W-1:0] o_re,
    output logic [W-1:0] o_im
);
    typedef struct packed {
        logic phase;
        logic [W-1:0] held_re;
        logic [W-1:0] held_im;
        logic out_valid;
        logic [W-1:0] out_re;
        logic [W-1:0] out_im;
    } sec_state_t;

    sec_state_t st;
    sec_state_t next_st;

    // average of two signed samples; the extra bit avoids overflow
    function automatic logic [W-1:0] avg(input logic [W-1:0] a,
                                         input logic [W-1:0] b);
        logic [W:0] s;
        s = {a[W-1], a} + {b[W-1], b};
        return s[W:1];
    endfunction : avg

    always_comb begin
        next_st = st;
        next_st.out_valid = 1'b0;
        if (i_flush) begin
            next_st = '0;
        end else if (i_valid) begin
            next_st.phase = ~st.phase;
            if (!st.phase) begin
                next_st.held_re = i_re;
                next_st.held_im = i_im;
            end else begin
                next_st.out_valid = 1'b1;
                next_st.out_re = avg(st.held_re, i_re);
                next_st.out_im = avg(st.held_im, i_im);
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_valid = st.out_valid;
    assign o_re = st.out_re;
    assign o_im = st.out_im;
endmodule : halving_section

/* dv/conv_stream_model.sv */
// converter sample stream model feeding the decimation filter
`timescale 1ns/100ps
module conv_stream_model #(
    parameter int W = 24
) (
    input wire logic i_mclk,
    output logic o_valid,
    output logic [W-1:0] o_re,
    output logic [W-1:0] o_im
);
    // ------------------------------------------------------------
    // sample pushes
    // ------------------------------------------------------------
    initial begin
        o_valid = 1'b0;
        o_re = '0;
        o_im = '0;
    end

    // between samples the lines show the inverse, never a stale value
    task automatic push(input logic [W-1:0] v);
        @(posedge i_mclk);
        o_valid <= 1'b1;
        o_re <= v;
        o_im <= ~v;
        @(posedge i_mclk);
        o_valid <= 1'b0;
        o_re <= ~v;
        o_im <= v;
    endtask : push
endmodule : conv_stream_model

/* dv/decim_filter_checker.sv */
// port-level assertions for the decimation filter
`timescale 1ns/100ps
`include "decim_regs.svh"
module decim_filter_checker #(
    parameter int W = 24
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_valid,
    input wire logic [W-1:0] i_re,
    input wire logic o_valid,
    input wire logic o_two_words,
    input wire logic [31:0] o_word_b,
    input wire logic [31:0] o_word_a,
    input wire logic o_running
);
    // ------------------------------------------------------------
    // shadow of the plain level-zero setting
    // ------------------------------------------------------------
    logic lvl0_single;
    logic cfg_wr;
    logic legal;
    assign cfg_wr = i_wr && i_addr == `REG_CFG;
    assign legal = !i_wdata[7] && !i_wdata[9] && !i_wdata[11]
        && !(i_wdata[10] && (i_wdata[7:0] != 8'h0 || i_wdata[13]));

    // refused writes leave the shadow as it was
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            lvl0_single <= 1'b1;
        end else if (cfg_wr && legal) begin
            lvl0_single <= (i_wdata[15:0] & 16'hcfff) == 16'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    a_cfg_forces_idle: assert property (
        cfg_wr |=> !o_running) else $error("cfg write left block running");
    a_trig_forces_idle: assert property (
        i_wr && i_addr == `REG_TRIG |=> !o_running)
        else $error("trig write left block running");
    a_start_runs: assert property (
        i_wr && i_addr == `REG_CMD && i_wdata[1:0] == 2'h1 && !o_running
        |=> o_running) else $error("start did not run");
    a_stop_wins: assert property (
        i_wr && i_addr == `REG_CMD && i_wdata[1] |=> !o_running)
        else $error("stop did not idle");
    a_level0_bypass: assert property (
        lvl0_single && o_running && i_valid && !i_wr
        |=> o_valid && o_word_a == {$past(i_re), {(32-W){1'b0}}})
        else $error("level zero sample not passed straight");
    a_real_one_word: assert property (
        lvl0_single && o_valid |-> !o_two_words && o_word_b == 32'h0)
        else $error("real output used second word");
    a_level_clamp: assert property (
        i_rd && i_addr == `REG_CFG |=> o_rdata[7:0] <= `MAX_LEVEL)
        else $error("level read above clamp");
    a_status_run: assert property (
        i_rd && i_addr == `REG_STATUS
        |=> o_rdata[0] == $past(o_running) && o_rdata[31:5] == 27'h0)
        else $error("status read wrong");
endmodule : decim_filter_checker

/* dv/decim_filter_tb.sv */
// self-checking testbench of the decimation filter
`timescale 1ns/100ps
`include "decim_regs.svh"
module decim_filter_tb;
    localparam int W = 24;
    logic i_mclk, i_reset, i_wr, i_rd;
    logic [`ADDR_W-1:0] i_addr;
    logic [31:0] i_wdata, o_rdata, o_word_a, o_word_b, o_trig_data;
    logic i_valid, o_valid, o_two_words, o_trig_valid, o_running;
    logic [W-1:0] i_re, i_im;
    logic [31:0] nout, ntrig, last_a, last_b, last_t, rv;
    logic two;
    int errors, checks;
    logic [W-1:0] s [6] = '{24'h64, 24'hc8, 24'h12c, 24'h1f4,
        24'h123400, 24'h123600};
    logic [31:0] ecfg [5] = '{32'hff, 32'h200, 32'h800, 32'h2400, 32'h402};
    logic [31:0] ebit [5] = '{32'h2, 32'h4, 32'h8, 32'h10, 32'h8};

    decim_filter #(.W(W), .NS(23)) u_dut (.i_mclk(i_mclk),
        .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(i_valid), .i_re(i_re),
        .i_im(i_im), .o_valid(o_valid), .o_two_words(o_two_words),
        .o_word_a(o_word_a), .o_word_b(o_word_b),
        .o_trig_valid(o_trig_valid), .o_trig_data(o_trig_data),
        .o_running(o_running));
    conv_stream_model #(.W(W)) u_src (.i_mclk(i_mclk), .o_valid(i_valid),
        .o_re(i_re), .o_im(i_im));

    // ------------------------------------------------------------
    // clock, monitor and shared tasks
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        if (o_valid === 1'b1) begin
            nout = nout + 1;
            last_a = o_word_a;
            last_b = o_word_b;
            two = o_two_words;
        end
        if (o_trig_valid === 1'b1) begin
            ntrig = ntrig + 1;
            last_t = o_trig_data;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    // configure, start, feed n samples from index f, then count outputs
    task automatic run(input logic [31:0] cfg, input int f, input int n,
            input logic [31:0] en, input logic [31:0] ea, input bit tr);
        nout = 0;
        ntrig = 0;
        wr(`REG_CFG, cfg);
        wr(`REG_CMD, 32'h1);
        for (int i = f; i < f + n; i++) u_src.push(s[i]);
        repeat (12) @(posedge i_mclk);
        check(nout, en);
        check(last_a, ea);
        if (tr) check(ntrig, en);
    endtask : run

    task automatic tally_and_finish;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #2000000;
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {i_reset, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 4'h0, 32'h0};
        {nout, ntrig, last_a, last_b, last_t, errors, checks} = '0;
        two = 1'b0;
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        rd(`REG_CFG, rv);
        check(rv, 32'h0);
        rd(4'h5, rv);
        check(rv, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(`REG_CFG, ecfg[i]);
            rd(`REG_STATUS, rv);
            check(rv, ebit[i]);
            rd(`REG_CFG, rv);
            check(rv, 32'h0);
            wr(`REG_STATUS, 32'h1e);
        end
        wr(`REG_TRIG, 32'h80);
        rd(`REG_STATUS, rv);
        check(rv, 32'h2);
        wr(`REG_STATUS, 32'h1e);
        wr(`REG_CFG, 32'h2000);
        rd(`REG_STATUS, rv);
        check(rv, 32'h0);
        wr(`REG_CFG, 32'h7f);
        rd(`REG_CFG, rv);
        check(rv, 32'h18);
        wr(`REG_CFG, 32'h118);
        rd(`REG_CFG, rv);
        check(rv, 32'h117);
        rd(`REG_TRIG, rv);
        check(rv, 32'h17);
        wr(`REG_CFG, 32'h11e);
        rd(`REG_CFG, rv);
        check(rv, 32'h117);
        wr(`REG_CFG, 32'h0);
        wr(`REG_CMD, 32'h1);
        rd(`REG_STATUS, rv);
        check(rv, 32'h1);
        wr(`REG_TRIG, 32'h0);
        rd(`REG_STATUS, rv);
        check(rv, 32'h0);
        wr(`REG_CMD, 32'h1);
        wr(`REG_CMD, 32'h3);
        rd(`REG_STATUS, rv);
        check(rv, 32'h0);
        run(32'h0, 0, 4, 32'h4, 32'h1f400, 1'b1);
        run(32'h1, 0, 4, 32'h4, 32'h1f400, 1'b1);
        run(32'h2, 0, 4, 32'h2, 32'h19000, 1'b1);
        run(32'h3, 0, 4, 32'h1, 32'h11300, 1'b1);
        check(last_t, 32'h11300);
        run(32'h101, 0, 4, 32'h2, 32'h12c00, 1'b1);
        run(32'h100, 0, 4, 32'h2, 32'h12c00, 1'b1);
        // complex output carries the imaginary word
        run(32'h8002, 0, 4, 32'h2, 32'h19000, 1'b1);
        check(last_b, 32'hfffe6f00);
        check({31'h0, two}, 32'h1);
        run(32'h400, 0, 4, 32'h3, 32'h11302, 1'b0);
        run(32'h400, 4, 2, 32'h1, 32'h12350001, 1'b0);
        run(32'h1400, 4, 2, 32'h1, 32'h12350100, 1'b0);
        run(32'h4400, 4, 2, 32'h1, 32'h12350001, 1'b0);
        run(32'hc400, 4, 2, 32'h1, 32'h1235edc1, 1'b0);
        run(32'h8400, 4, 2, 32'h1, 32'h12350001, 1'b0);
        check(last_b, 32'hedcaff01);
        tally_and_finish();
    end
endmodule : decim_filter_tb

bind decim_filter decim_filter_checker #(.W(W)) u_chk (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(i_valid), .i_re(i_re),
    .o_valid(o_valid), .o_two_words(o_two_words), .o_word_b(o_word_b),
    .o_word_a(o_word_a), .o_running(o_running));
